//--- hw/spi_ram_irq_wake_logic.sv
`timescale 1ns/1ps
`include "irq_wake_params.svh"
// Contract
// R1: Enable bit 15 gates receive FIFO underrun interrupt; resets 0.
// R2: Enable bit 14 gates receive FIFO overrun interrupt; resets 0.
// R3: Enable bit 13 gates transmit FIFO underrun interrupt; resets 0.
// R4: Enable bit 12 gates transmit FIFO overrun interrupt; resets 0.
// R5: Enable bit 11 gates controller transfers done interrupt; resets 0.
// R6: Enable bit 9 gates target abort interrupt; resets 0.
// R7: Enable bit 8 gates multi-controller fault interrupt; resets 0.
// R8: Enable bit 5 gates target select deasserted interrupt; resets 0.
// R9: Enable bit 4 gates target select asserted interrupt; resets 0.
// R10: Enable bit 3 gates receive FIFO full interrupt; resets 0.
// R11: Enable bit 2 gates receive FIFO threshold interrupt; resets 0.
// R12: Enable bit 1 gates transmit FIFO empty interrupt; resets 1.
// R13: Enable bit 0 gates transmit FIFO threshold interrupt; resets 0.
// R14: Wake cause bit 3 records receive full wake; write 1 clears.
// R15: Wake cause bit 2 records receive threshold wake; write 1 clears.
// R16: Wake cause bit 1 records transmit empty wake; write 1 clears.
// R17: Wake cause bit 0 records transmit threshold wake; write 1 clears.
// R18: A FIFO wake happens only when its wake enable bit is 1.
// R19: Transmit empty flag sets while transmit FIFO empty; resets to 1.
// R20: Interrupt asserted while any flag and its enable both set.
module spi_ram_irq_wake_logic (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] event_set,
    input  wire logic        tx_fifo_empty,
    input  wire logic        low_power,
    output logic             irq,
    output logic             wake
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Unmapped offsets answer with an error and touch no state
    function automatic logic mapped(input logic [7:0] a);
        logic hit;
        case (a)
            `OFS_INT_STATUS,
            `OFS_INT_ENABLE,
            `OFS_WAKE_CAUSE,
            `OFS_WAKE_ENABLE: hit = 1'b1;
            default:          hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Byte lanes below a word are ignored, so every decode sees an aligned offset
    function automatic logic [7:0] word_addr(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    irq_wake_pkg::wr_state_t wr_state_q;
    logic                    aw_have_q;
    logic                    w_have_q;
    logic [7:0]              aw_addr_q;
    logic [31:0]             w_data_q;
    logic [3:0]              w_strb_q;
    logic                    wr_fire;
    logic [15:0]             int_enable_q;
    logic [3:0]              wake_enable_q;
    logic [15:0]             int_status;
    logic [3:0]              wake_cause;
    logic [15:0]             int_clr;
    logic [3:0]              wake_clr;
    logic [3:0]              wake_set;
    logic [15:0]             status_set;
    logic [31:0]             wmask;
    logic [31:0]             en_merged;
    logic [31:0]             wen_merged;
    logic [3:0]              wake_src;
    // Sleep-level synchroniser stages
    logic                    lp_meta_q;
    logic                    lp_sync_q;

    assign s_axi_awready = (wr_state_q == irq_wake_pkg::WR_IDLE) && !aw_have_q;
    assign s_axi_wready  = (wr_state_q == irq_wake_pkg::WR_IDLE) && !w_have_q;
    assign wr_fire       = (wr_state_q == irq_wake_pkg::WR_IDLE) && aw_have_q && w_have_q;
    assign wmask         = lane_merge(32'h0000_0000, w_data_q, w_strb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= word_addr(s_axi_awaddr);
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q   <= irq_wake_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
        end else begin
            case (wr_state_q)
                irq_wake_pkg::WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_q   <= irq_wake_pkg::WR_RESP;
                        s_axi_bvalid <= 1'b1;
                    end
                end
                irq_wake_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q   <= irq_wake_pkg::WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_q   <= irq_wake_pkg::WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Write response
    // ----------------------------------------
    // The code is fixed when the write lands, so it stands unchanged beside bvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= `AXI_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bresp <= mapped(aw_addr_q) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end
    end

    // ----------------------------------------
    // Enable registers
    // ----------------------------------------
    assign en_merged  = lane_merge({16'h0000, int_enable_q}, w_data_q, w_strb_q);
    assign wen_merged = lane_merge({28'h000_0000, wake_enable_q}, w_data_q, w_strb_q);

    // Reserved bits are masked so they read zero and ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_enable_q <= `INT_ENABLE_RST; // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13
        end else if (wr_fire && aw_addr_q == `OFS_INT_ENABLE) begin
            int_enable_q <= en_merged[15:0] & `INT_IMPL_MASK; // R20
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_enable_q <= `WAKE_RST;
        end else if (wr_fire && aw_addr_q == `OFS_WAKE_ENABLE) begin
            wake_enable_q <= wen_merged[3:0] & `WAKE_IMPL_MASK;
        end
    end

    // ----------------------------------------
    // Status and wake-cause flags
    // ----------------------------------------
    // Transmit empty is a level: it re-sets every cycle the FIFO stays empty
    always_comb begin
        status_set                = event_set & `INT_IMPL_MASK;
        status_set[`BIT_TX_EMPTY] = event_set[`BIT_TX_EMPTY] | tx_fifo_empty; // R19
    end

    assign int_clr  = (wr_fire && aw_addr_q == `OFS_INT_STATUS) ?
                      wmask[15:0] & `INT_IMPL_MASK : 16'h0000;
    assign wake_clr = (wr_fire && aw_addr_q == `OFS_WAKE_CAUSE) ?
                      wmask[3:0] : 4'h0; // R14 R15 R16 R17

    // ----------------------------------------
    // Wake causes
    // ----------------------------------------
    // Only the four FIFO conditions may wake the device
    assign wake_src = {status_set[`BIT_RX_FULL], status_set[`BIT_RX_THRESH],
                       status_set[`BIT_TX_EMPTY], status_set[`BIT_TX_THRESH]};

    // The sleep level comes from the power controller's domain, so two flops settle it first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lp_meta_q <= 1'b0;
        end else begin
            lp_meta_q <= low_power;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lp_sync_q <= 1'b0;
        end else begin
            lp_sync_q <= lp_meta_q;
        end
    end

    // Cause is only latched while asleep and enabled, so stray events never wake
    // Limitation: a cause can still latch for two cycles after the sleep level falls
    assign wake_set = {4{lp_sync_q}} & wake_enable_q & wake_src; // R18

    w1c_flags #(
        .W   (16),
        .RST (`INT_STATUS_RST)
    ) u_status (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (status_set),
        .clr     (int_clr),
        .flags   (int_status)
    );

    w1c_flags #(
        .W   (4),
        .RST (`WAKE_RST)
    ) u_wake (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (wake_set),
        .clr     (wake_clr),
        .flags   (wake_cause) // R14 R15 R16 R17
    );

    // ----------------------------------------
    // Outputs to interrupt and wake logic
    // ----------------------------------------
    // Registered so the request line never glitches while flags and enables settle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_enable_q); // R20 R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13
        end
    end

    // Wake stays up until software clears every cause bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake <= 1'b0;
        end else begin
            wake <= |wake_cause; // R18
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    irq_wake_pkg::rd_state_t rd_state_q;
    logic [31:0]             rd_word;

    assign s_axi_arready = (rd_state_q == irq_wake_pkg::RD_IDLE);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (word_addr(s_axi_araddr))
            `OFS_INT_STATUS:  rd_word = {16'h0000, int_status};
            `OFS_INT_ENABLE:  rd_word = {16'h0000, int_enable_q};
            `OFS_WAKE_CAUSE:  rd_word = {28'h000_0000, wake_cause};
            `OFS_WAKE_ENABLE: rd_word = {28'h000_0000, wake_enable_q};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q   <= irq_wake_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
        end else begin
            case (rd_state_q)
                irq_wake_pkg::RD_IDLE: begin
                    // arready is high exactly here, so arvalid alone marks a taken read
                    if (s_axi_arvalid) begin
                        rd_state_q   <= irq_wake_pkg::RD_DATA;
                        s_axi_rvalid <= 1'b1;
                    end
                end
                irq_wake_pkg::RD_DATA: begin
                    if (s_axi_rready) begin
                        rd_state_q   <= irq_wake_pkg::RD_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default: begin
                    rd_state_q   <= irq_wake_pkg::RD_IDLE;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Loaded only when a read is taken, so data and code stand until rready
    // Reserved offsets read zero with an error code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= mapped(word_addr(s_axi_araddr)) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end
    end
endmodule // spi_ram_irq_wake_logic

//--- hw/irq_wake_params.svh
`ifndef IRQ_WAKE_PARAMS_SVH
`define IRQ_WAKE_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_INT_STATUS   8'h20
`define OFS_INT_ENABLE   8'h24
`define OFS_WAKE_CAUSE   8'h28
`define OFS_WAKE_ENABLE  8'h2C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_RX_UND       15
`define BIT_RX_OVR       14
`define BIT_TX_UND       13
`define BIT_TX_OVR       12
`define BIT_M_DONE       11
`define BIT_ABORT        9
`define BIT_FAULT        8
`define BIT_SSD          5
`define BIT_SSA          4
`define BIT_RX_FULL      3
`define BIT_RX_THRESH    2
`define BIT_TX_EMPTY     1
`define BIT_TX_THRESH    0
// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define INT_IMPL_MASK    16'hFB3F
`define INT_ENABLE_RST   16'h0002
`define INT_STATUS_RST   16'h0002
`define WAKE_IMPL_MASK   4'hF
`define WAKE_RST         4'h0
`define AXI_RESP_OKAY    2'b00
`define AXI_RESP_SLVERR  2'b10
`endif

//--- hw/irq_wake_pkg.sv
package irq_wake_pkg;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_DATA = 2'b01
    } rd_state_t;
endpackage

//--- hw/w1c_flags.sv
`timescale 1ns/1ps
// Sticky flag bank: set beats write-one-to-clear in the same cycle.
module w1c_flags #(
    parameter int           W   = 4,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= RST;
        end else begin
            flags <= (flags & ~clr) | set;
        end
    end
endmodule // w1c_flags

//--- sim/irq_wake_checker.sv
`timescale 1ns/1ps
module irq_wake_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        low_power,
    input wire logic        irq,
    input wire logic        wake
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp)) else $error("read answer dropped");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    // ----------------------------------------
    // Reset and events
    // ----------------------------------------
    reset_quiet_a: assert property ($rose(aresetn) |-> !irq && !wake && !s_axi_bvalid)
        else $error("outputs not idle after reset");
    reset_irq_a: assert property ($rose(aresetn) |=> irq)
        else $error("transmit empty interrupt missing after reset");
    wake_sleep_a: assert property ($rose(wake) |-> $past(low_power, 4))
        else $error("wake raised while awake");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(wake));
endmodule // irq_wake_checker

//--- sim/sleep_ctrl_model.sv
`timescale 1ns/1ps
// Low-power controller: sleeps on request, a wake event ends the sleep
module sleep_ctrl_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic sleep_req,
    input  wire logic wake,
    output logic      low_power
);
    always_ff @(posedge aclk) begin
        if (!aresetn) low_power <= 1'b0;
        else if (wake) low_power <= 1'b0;
        else if (sleep_req) low_power <= 1'b1;
    end
endmodule // sleep_ctrl_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "irq_wake_params.svh"
module tb_top;
    logic        aclk, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdt, d, m;
    logic [3:0]  ws = 4'h0;
    logic [15:0] ev = 16'h0000;
    logic        awr, wr_rdy, bv, arr, rv, irq, wake, lp, txe = 1'b0, slp = 1'b0;
    logic [1:0]  bre, rre, r;
    int          err_count = 0, checked = 0, cycles = 0;
    int          bits [13] = '{15, 14, 13, 12, 11, 9, 8, 5, 4, 3, 2, 1, 0};
    spi_ram_irq_wake_logic uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .event_set(ev), .tx_fifo_empty(txe), .low_power(lp), .irq(irq), .wake(wake));
    sleep_ctrl_model pm (.aclk(aclk), .aresetn(aresetn), .sleep_req(slp), .wake(wake), .low_power(lp));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Readies and answers are taken at the rising edge; one edge passes before the next call drives again
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] o);
        logic tb;
        tb = 1'b0;
        awa <= a; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        while (!tb) begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
            tb = bv;
            o = bre;
        end
        br <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
        logic tb;
        tb = 1'b0;
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        while (!tb) begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            tb = rv;
            v = rdt;
            o = rre;
        end
        rr <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic pulse(input logic [15:0] p);
        ev <= p;
        @(posedge aclk);
        ev <= 16'h0000;
        repeat (3) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin err_count++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end
    endtask
    task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
        checked++;
        if (g !== e) begin err_count++; $display("unexpected at %0t: response %b expected %b", $time, g, e); end
    endtask
    task automatic summarize;
        $display("mismatches %0d of %0d comparisons", err_count, checked);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 8000) begin err_count++; $display("unexpected at %0t: run hung", $time); summarize(); end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`OFS_INT_ENABLE, d, r); chk(d, 32'h0000_0002);
        chk_r(r, `AXI_RESP_OKAY);
        rd(`OFS_WAKE_CAUSE, d, r); chk(d, 32'h0000_0000);
        rd(`OFS_INT_STATUS, d, r); chk(d, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        $display("reset test done");
        wr(`OFS_INT_ENABLE, 32'hFFFF_FFFF, 4'h1, r);
        rd(`OFS_INT_ENABLE, d, r); chk(d, 32'h0000_003F);
        wr(`OFS_INT_ENABLE, 32'hFFFF_FFFF, 4'hF, r);
        rd(`OFS_INT_ENABLE, d, r); chk(d, 32'h0000_FB3F);
        wr(8'h40, 32'hFFFF_FFFF, 4'hF, r); chk_r(r, `AXI_RESP_SLVERR);
        rd(8'h40, d, r); chk(d, 32'h0000_0000);
        chk_r(r, `AXI_RESP_SLVERR);
        wr(`OFS_INT_ENABLE, 32'h0000_0000, 4'hF, r);
        $display("map test done");
        for (int i = 0; i < 13; i++) begin
            m = 32'h0000_0001 << bits[i];
            wr(`OFS_INT_STATUS, 32'h0000_FFFF, 4'hF, r);
            pulse(m[15:0]);
            chk({31'h0, irq}, 32'h0000_0000);
            wr(`OFS_INT_ENABLE, m, 4'hF, r);
            repeat (2) @(posedge aclk);
            chk({31'h0, irq}, 32'h0000_0001);
            wr(`OFS_INT_ENABLE, 32'h0000_0000, 4'hF, r);
        end
        $display("gating test done");
        slp <= 1'b1;
        @(posedge aclk);
        slp <= 1'b0;
        repeat (3) @(posedge aclk);
        pulse(16'h000D);
        rd(`OFS_WAKE_CAUSE, d, r); chk(d, 32'h0000_0000);
        chk({31'h0, lp}, 32'h0000_0001);
        wr(`OFS_WAKE_ENABLE, 32'h0000_000F, 4'hF, r);
        txe <= 1'b1;
        pulse(16'h000D);
        rd(`OFS_WAKE_CAUSE, d, r); chk(d, 32'h0000_000F);
        chk({31'h0, lp}, 32'h0000_0000);
        chk({31'h0, wake}, 32'h0000_0001);
        wr(`OFS_WAKE_CAUSE, 32'h0000_0008, 4'hF, r);
        rd(`OFS_WAKE_CAUSE, d, r); chk(d, 32'h0000_0007);
        wr(`OFS_WAKE_CAUSE, 32'h0000_0007, 4'hF, r);
        rd(`OFS_WAKE_CAUSE, d, r); chk(d, 32'h0000_0000);
        chk({31'h0, wake}, 32'h0000_0000);
        wr(`OFS_INT_STATUS, 32'h0000_FFFF, 4'hF, r);
        rd(`OFS_INT_STATUS, d, r); chk(d, 32'h0000_0002);
        $display("wake test done");
        summarize();
    end
endmodule // tb_top
bind spi_ram_irq_wake_logic irq_wake_checker chk_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .low_power(low_power), .irq(irq), .wake(wake));
